// [design/tmr_pkg.sv]
package tmr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_START_STOP = 8'h0E;
  localparam logic [7:0] IDX_T0_CTRL = 8'h0F;
  localparam logic [7:0] IDX_T0_RELOAD_HI = 8'h10;
  localparam logic [7:0] IDX_T0_RELOAD_LO = 8'h11;
  localparam logic [7:0] IDX_T0_COUNT_HI = 8'h12;
  localparam logic [7:0] IDX_T0_COUNT_LO = 8'h13;
  localparam int ADDR_SHIFT = 2;

  // Start/stop register layout
  localparam int MASK_LSB = 0;
  localparam int ACTIVE_LSB = 4;
  localparam int NUM_TIMERS = 4;

  // Timer zero control layout
  localparam int CTRL_HALT_RX_BIT = 7;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_RESTART_BIT = 3;
  localparam int CTRL_CLK_LSB = 0;
  localparam logic [7:0] CTRL_RW_MASK = 8'hBB;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [3:0] ACTIVE_RESET = 4'h0;

  // Start modes
  typedef enum logic [1:0] {
    TMR_START_MANUAL = 2'b00,
    TMR_START_TX_END = 2'b01,
    TMR_START_LFO_NOUF = 2'b10,
    TMR_START_LFO_UF = 2'b11
  } tmr_start_mode_t;

  // Tick sources
  typedef enum logic [1:0] {
    TMR_CLK_FAST = 2'b00,
    TMR_CLK_SLOW = 2'b01,
    TMR_CLK_T2_UF = 2'b10,
    TMR_CLK_T1_UF = 2'b11
  } tmr_clk_sel_t;

  // Tick timing, rates in kHz
  localparam int MCLK_KHZ = 125000;
  localparam int FAST_KHZ = 13560;
  localparam int SLOW_DIV = 64;
  localparam int SLOW_DIV_W = 6;
  localparam int ACC_W = 18;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(MCLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(FAST_KHZ);
  localparam logic [SLOW_DIV_W-1:0] SLOW_LAST = SLOW_DIV_W'(SLOW_DIV - 1);

endpackage

// [design/tmr_tick_gen.sv]
`timescale 1ns/1ps
module tmr_tick_gen (
  input wire logic mclk,
  input wire logic rst,
  output logic tick_fast,
  output logic tick_slow
);

  logic [tmr_pkg::ACC_W-1:0] acc_q;
  logic [tmr_pkg::ACC_W-1:0] acc_sum;
  logic [tmr_pkg::SLOW_DIV_W-1:0] div_q;
  logic fast_d;

  // Fractional accumulator gives 13.56 MHz average tick rate
  always_comb begin
    acc_sum = acc_q + tmr_pkg::ACC_INC;
    fast_d = (acc_sum >= tmr_pkg::ACC_MOD);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q <= '0;
    end else if (fast_d) begin
      acc_q <= acc_sum - tmr_pkg::ACC_MOD;
    end else begin
      acc_q <= acc_sum;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_fast <= 1'b0;
    end else begin
      tick_fast <= fast_d;
    end
  end

  // Divide by 64 for the 211.875 kHz tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q <= '0;
      tick_slow <= 1'b0;
    end else begin
      tick_slow <= 1'b0;
      if (fast_d) begin
        div_q <= div_q + 1'b1;
        tick_slow <= (div_q == tmr_pkg::SLOW_LAST);
      end
    end
  end

endmodule

// [design/tmr_top.sv]
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
// Behaviour
// - Low mask nibble gates writes to running bits
// - FFh sets all; F0h changes nothing
// - Bits 7..4 show timers three..zero counting
// - Masked write starts or stops immediately
// - Halt bit stops timer after first rx bits
// - Halt bit ignored in oscillator trimming modes
// - Mode zero: start only by software
// - Mode one: start at end of transmission
// - Modes two, three: trimming on rising edges
// - Auto restart, except in mode two, reloads and continues at zero
// - No auto restart, except in mode two: stop at zero, clear running
// - Every underflow sets timer interrupt flag
// - Clock select zero fast, one slow tick
// - Clock select two, three cascade other underflows
// - Start loads counter from reload word
// - Reload writes affect only next start or auto restart
// - Count high byte readable, read only
// - Count low byte readable at 13h
module tmr_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tx_end,
  input wire logic rx_first_bits,
  input wire logic low_freq_oscillator,
  input wire logic timer_one_underflow,
  input wire logic timer_two_underflow,
  output logic timer_zero_active,
  output logic timer_one_active,
  output logic timer_two_active,
  output logic timer_three_active,
  output logic timer_underflow_flag
);

  // Architectural registers
  logic [7:0] ctrl_q;
  logic [7:0] reload_hi_q;
  logic [7:0] reload_lo_q;
  logic [15:0] count_q;
  logic [3:0] active_q;
  logic lfo_q;

  // Bus pipeline state
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic rd_pend_q;
  logic rd_done_q;
  logic [7:0] rd_idx_q;
  logic [31:0] hrdata_q;

  // Address decode and write strobes
  logic addr_ok;
  logic accept;
  logic [7:0] wdata;
  logic wr_start_stop;
  logic wr_ctrl;
  logic wr_reload_hi;
  logic wr_reload_lo;
  logic [3:0] wr_mask;
  logic [3:0] wr_active;

  // Timer datapath
  logic tick_fast;
  logic tick_slow;
  logic tick;
  logic lfo_rise;
  logic lfo_mode;
  logic [15:0] timer_zero_reload_word;
  logic sw_start;
  logic sw_stop;
  logic hw_start;
  logic hw_stop;
  logic underflow;
  logic uf_stop;
  logic start_evt;
  logic stop_evt;
  logic [7:0] rd_val;
  logic [15:0] count_d;
  logic [3:0] active_d;
  logic rd_load;
  logic count_zero;
  logic uf_enabled;

  // Control fields
  tmr_pkg::tmr_start_mode_t auto_start_mode;
  tmr_pkg::tmr_clk_sel_t tick_source_select;
  logic halt_on_first_rx_bits;
  logic reload_on_zero;

  tmr_tick_gen u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick_fast(tick_fast),
    .tick_slow(tick_slow)
  );

  // Only the low byte of each word is meaningful; upper data bits are
  // ignored on writes and read back as zero. Misaligned addresses are
  // accepted with an OKAY response but touch nothing.
  // Bus address phase decode
  assign addr_ok = (haddr[tmr_pkg::ADDR_SHIFT-1:0] == 2'b00);
  assign accept = hsel && htrans[1] && hready;

  // Write data phase follows an accepted write address phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
    end else if (accept) begin
      wr_pend_q <= hwrite && addr_ok;
      wr_idx_q <= haddr[tmr_pkg::ADDR_SHIFT+7:tmr_pkg::ADDR_SHIFT];
    end else if (hready) begin
      wr_pend_q <= 1'b0;
    end
  end

  // Reads take one wait state so a preceding write is visible
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_done_q <= 1'b0;
      rd_idx_q <= '0;
    end else if (accept) begin
      rd_pend_q <= !hwrite;
      rd_done_q <= 1'b0;
      rd_idx_q <= addr_ok ? haddr[tmr_pkg::ADDR_SHIFT+7:tmr_pkg::ADDR_SHIFT] : 8'hFF;
    end else if (rd_pend_q && !rd_done_q) begin
      rd_done_q <= 1'b1;
    end else if (hready) begin
      rd_pend_q <= 1'b0;
      rd_done_q <= 1'b0;
    end
  end

  // Register file is sampled during the single wait state
  assign rd_load = rd_pend_q && !rd_done_q;
  assign hreadyout = !rd_load;
  // Every transfer completes with an OKAY response
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Write data phase strobes
  // Writes need no wait state
  assign wdata = hwdata[7:0];
  assign wr_start_stop = wr_pend_q && (wr_idx_q == tmr_pkg::IDX_START_STOP);
  assign wr_ctrl = wr_pend_q && (wr_idx_q == tmr_pkg::IDX_T0_CTRL);
  assign wr_reload_hi = wr_pend_q && (wr_idx_q == tmr_pkg::IDX_T0_RELOAD_HI);
  assign wr_reload_lo = wr_pend_q && (wr_idx_q == tmr_pkg::IDX_T0_RELOAD_LO);
  assign wr_mask = wr_start_stop ? wdata[tmr_pkg::MASK_LSB +: tmr_pkg::NUM_TIMERS] : 4'h0;
  assign wr_active = wdata[tmr_pkg::ACTIVE_LSB +: tmr_pkg::NUM_TIMERS];

  // Reserved control bits are held at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= tmr_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata & tmr_pkg::CTRL_RW_MASK;
    end
  end

  // Reload bytes never touch the running count
  always_ff @(posedge mclk) begin
    if (rst) begin
      reload_hi_q <= tmr_pkg::RELOAD_RESET;
      reload_lo_q <= tmr_pkg::RELOAD_RESET;
    end else begin
      if (wr_reload_hi) begin
        reload_hi_q <= wdata;
      end
      if (wr_reload_lo) begin
        reload_lo_q <= wdata;
      end
    end
  end

  // High byte forms the upper half of the reload word
  assign timer_zero_reload_word = {reload_hi_q, reload_lo_q};

  // Control fields
  assign halt_on_first_rx_bits = ctrl_q[tmr_pkg::CTRL_HALT_RX_BIT];
  assign auto_start_mode = tmr_pkg::tmr_start_mode_t'(ctrl_q[tmr_pkg::CTRL_MODE_LSB +: 2]);
  assign reload_on_zero = ctrl_q[tmr_pkg::CTRL_RESTART_BIT];
  assign tick_source_select = tmr_pkg::tmr_clk_sel_t'(ctrl_q[tmr_pkg::CTRL_CLK_LSB +: 2]);

  // The fast and slow ticks are single-cycle enables; the cascaded underflow
  // inputs are taken as levels, so they decrement the count on every cycle they are high.
  always_comb begin
    unique case (tick_source_select)
      tmr_pkg::TMR_CLK_FAST: tick = tick_fast;
      tmr_pkg::TMR_CLK_SLOW: tick = tick_slow;
      tmr_pkg::TMR_CLK_T2_UF: tick = timer_two_underflow;
      tmr_pkg::TMR_CLK_T1_UF: tick = timer_one_underflow;
    endcase
  end

  // Oscillator edge detect
  // Resets low, matching the idle level of the oscillator input
  always_ff @(posedge mclk) begin
    if (rst) begin
      lfo_q <= 1'b0;
    end else begin
      lfo_q <= low_freq_oscillator;
    end
  end

  assign lfo_rise = low_freq_oscillator && !lfo_q;
  // Both trimming modes start and stop on rising edges
  assign lfo_mode = (auto_start_mode == tmr_pkg::TMR_START_LFO_NOUF) ||
                    (auto_start_mode == tmr_pkg::TMR_START_LFO_UF);

  // Software reaches timer zero through the start/stop register mask;
  // hardware reaches it through the transmit, receive and oscillator
  // events, qualified by the start mode.
  // Start and stop sources for timer zero
  assign sw_start = wr_mask[0] && wr_active[0];
  assign sw_stop = wr_mask[0] && !wr_active[0];

  // Receive halt applies only outside the trimming modes
  always_comb begin
    hw_start = 1'b0;
    hw_stop = halt_on_first_rx_bits && rx_first_bits && !lfo_mode;
    unique case (auto_start_mode)
      tmr_pkg::TMR_START_MANUAL: begin
        hw_start = 1'b0;
      end
      tmr_pkg::TMR_START_TX_END: begin
        hw_start = tx_end && !active_q[0];
      end
      tmr_pkg::TMR_START_LFO_NOUF, tmr_pkg::TMR_START_LFO_UF: begin
        hw_start = lfo_rise && !active_q[0];
        hw_stop = lfo_rise && active_q[0];
      end
    endcase
  end

  // Underflow at a tick while count is zero; mode two wraps without it
  assign count_zero = (count_q == '0);
  assign uf_enabled = (auto_start_mode != tmr_pkg::TMR_START_LFO_NOUF);
  assign underflow = active_q[0] && tick && count_zero && uf_enabled;
  assign uf_stop = underflow && !reload_on_zero;

  // Software write wins over hardware events in the same cycle
  assign start_evt = sw_start || (!sw_stop && hw_start);
  assign stop_evt = sw_stop || (!sw_start && !hw_start && (hw_stop || uf_stop));

  // The count is not touched by reload writes; a new reload word only
  // matters at the next start or automatic restart.
  always_comb begin
    count_d = count_q;
    if (start_evt) begin
      count_d = timer_zero_reload_word;
    end else if (active_q[0] && !stop_evt && tick) begin
      if (underflow) begin
        count_d = timer_zero_reload_word;
      end else begin
        count_d = count_q - 16'h0001;
      end
    end
  end

  // A stopped timer simply holds its count
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= tmr_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // Timers one to three: running bits follow masked software writes only
  for (genvar g = 1; g < tmr_pkg::NUM_TIMERS; g++) begin : g_active
    assign active_d[g] = wr_mask[g] ? wr_active[g] : active_q[g];
  end

  // Timer zero: a start beats any stop in the same cycle except a software stop
  assign active_d[0] = start_evt || (!stop_evt && active_q[0]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      active_q <= tmr_pkg::ACTIVE_RESET;
    end else begin
      active_q <= active_d;
    end
  end

  // Running bits leave the block as separate levels
  assign timer_zero_active = active_q[0];
  assign timer_one_active = active_q[1];
  assign timer_two_active = active_q[2];
  assign timer_three_active = active_q[3];

  // One-cycle pulse per underflow; the sticky copy is held elsewhere
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_underflow_flag <= 1'b0;
    end else begin
      timer_underflow_flag <= underflow;
    end
  end

  // Count bytes are separate snapshots, not latched as a pair
  // Read mux; mask nibble and reserved bits read zero
  always_comb begin
    unique case (rd_idx_q)
      tmr_pkg::IDX_START_STOP: rd_val = {active_q, 4'h0};
      tmr_pkg::IDX_T0_CTRL: rd_val = ctrl_q;
      tmr_pkg::IDX_T0_RELOAD_HI: rd_val = reload_hi_q;
      tmr_pkg::IDX_T0_RELOAD_LO: rd_val = reload_lo_q;
      tmr_pkg::IDX_T0_COUNT_HI: rd_val = count_q[15:8];
      tmr_pkg::IDX_T0_COUNT_LO: rd_val = count_q[7:0];
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_load) begin
      hrdata_q <= {24'h00_0000, rd_val};
    end
  end

endmodule

// [verif/test_tmr_top.sv]
`timescale 1ns/1ps
module test_tmr_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [3:0] ta;
  logic [3:0] act;
  logic [7:0] d;
  logic hreadyout;
  logic hresp;
  logic flag;
  int n_errors = 0;
  int n_compared = 0;
  int n_flag = 0;
  localparam logic [7:0] SS = tmr_pkg::IDX_START_STOP;
  localparam logic [7:0] CT = tmr_pkg::IDX_T0_CTRL;

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (flag === 1'b1) n_flag <= n_flag + 1;

  tmr_top i_tmr_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_end(ev[0]),
    .rx_first_bits(ev[1]), .low_freq_oscillator(ev[2]), .timer_one_underflow(ev[3]),
    .timer_two_underflow(ev[4]), .timer_zero_active(ta[0]), .timer_one_active(ta[1]),
    .timer_two_active(ta[2]), .timer_three_active(ta[3]), .timer_underflow_flag(flag));

  function automatic int exp_fast(input int cyc, input int rl);
    return rl - cyc * tmr_pkg::FAST_KHZ / tmr_pkg::MCLK_KHZ;
  endfunction

  function automatic int exp_slow(input int cyc, input int rl);
    return rl - cyc * tmr_pkg::FAST_KHZ / tmr_pkg::MCLK_KHZ / tmr_pkg::SLOW_DIV;
  endfunction

  task complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task wait_rdy;
    int k;
    k = 0;
    @(negedge mclk);
    while (hreadyout !== 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    if (k == 50) begin
      n_errors++;
      complete_run;
    end
  endtask

  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy;
    @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    r = hrdata;
    @(posedge mclk);
  endtask

  task rc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(r, exp);
  endtask

  task pulse(input int b);
    ev <= 5'h01 << b;
    @(posedge mclk);
    ev <= 5'h00;
    repeat (3) @(posedge mclk);
  endtask

  task act_chk(input logic [3:0] e);
    @(negedge mclk);
    chk({28'h0, ta}, {28'h0, e});
    @(posedge mclk);
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    complete_run;
  end

  initial begin
    void'($urandom(34297));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 14; i < 20; i++) rc(8'(i), 32'h0);
    bus(1'b1, 8'h30, 32'hFF);
    rc(8'h30, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b1, CT, 32'hFF);
    rc(CT, 32'hBB);
    bus(1'b1, CT, 32'h00);
    bus(1'b1, 8'h10, 32'hFF);
    bus(1'b1, 8'h11, 32'hFF);
    act = 4'h0;
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'hF0 : 8'($urandom());
      bus(1'b1, SS, {24'h0, d});
      act = (act & ~d[3:0]) | (d[7:4] & d[3:0]);
      act_chk(act);
      rc(SS, {24'h0, act, 4'h0});
    end
    bus(1'b1, SS, 32'h0F);
    // Cascade from timer two, timer one ticks ignored
    bus(1'b1, CT, 32'h02);
    bus(1'b1, 8'h10, 32'h01);
    bus(1'b1, 8'h11, 32'h03);
    bus(1'b1, SS, 32'h11);
    repeat (3) pulse(4);
    pulse(3);
    rc(8'h12, 32'h01);
    rc(8'h13, 32'h00);
    bus(1'b1, 8'h11, 32'h55);
    rc(8'h13, 32'h00);
    pulse(4);
    rc(8'h12, 32'h00);
    rc(8'h13, 32'hFF);
    bus(1'b1, SS, 32'h01);
    pulse(4);
    rc(8'h13, 32'hFF);
    // Underflow without and with restart
    bus(1'b1, CT, 32'h03);
    bus(1'b1, 8'h10, 32'h00);
    bus(1'b1, 8'h11, 32'h02);
    bus(1'b1, SS, 32'h11);
    repeat (3) pulse(3);
    act_chk(4'h0);
    chk(32'(n_flag), 32'h1);
    bus(1'b1, CT, 32'h0B);
    bus(1'b1, SS, 32'h11);
    repeat (3) pulse(3);
    act_chk(4'h1);
    rc(8'h13, 32'h02);
    chk(32'(n_flag), 32'h2);
    bus(1'b1, SS, 32'h01);
    // Start modes
    bus(1'b1, CT, 32'h02);
    pulse(0);
    act_chk(4'h0);
    bus(1'b1, CT, 32'h92);
    pulse(0);
    act_chk(4'h1);
    pulse(1);
    act_chk(4'h0);
    bus(1'b1, CT, 32'hA2);
    pulse(2);
    act_chk(4'h1);
    pulse(1);
    act_chk(4'h1);
    pulse(2);
    act_chk(4'h0);
    // Fast tick rate over a fixed span
    bus(1'b1, CT, 32'h00);
    bus(1'b1, 8'h10, 32'h01);
    bus(1'b1, 8'h11, 32'h00);
    bus(1'b1, SS, 32'h11);
    repeat (640) @(posedge mclk);
    bus(1'b1, SS, 32'h01);
    bus(1'b0, 8'h13, 32'h0);
    d = 8'(exp_fast(640, 256));
    chk({31'h0, r[7:0] + 8'h03 >= d && r[7:0] <= d + 8'h03}, 32'h1);
    // Slow tick over a fixed span
    bus(1'b1, CT, 32'h01);
    bus(1'b1, 8'h10, 32'h00);
    bus(1'b1, 8'h11, 32'h10);
    bus(1'b1, SS, 32'h11);
    repeat (2000) @(posedge mclk);
    bus(1'b1, SS, 32'h01);
    bus(1'b0, 8'h13, 32'h0);
    d = 8'(exp_slow(2000, 16));
    chk({31'h0, r[7:0] + 8'h01 >= d && r[7:0] <= d + 8'h01}, 32'h1);
    // Trimming with underflow stops; without it the count wraps
    bus(1'b1, CT, 32'h33);
    bus(1'b1, 8'h11, 32'h01);
    pulse(2);
    repeat (2) pulse(3);
    act_chk(4'h0);
    chk(32'(n_flag), 32'h3);
    bus(1'b1, CT, 32'h23);
    pulse(2);
    repeat (2) pulse(3);
    act_chk(4'h1);
    rc(8'h12, 32'hFF);
    chk(32'(n_flag), 32'h3);
    pulse(2);
    act_chk(4'h0);
    complete_run;
  end
endmodule

// [verif/tmr_chk_sva.sv]
`timescale 1ns/1ps
module tmr_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic tx_end,
  input wire logic rx_first_bits,
  input wire logic timer_zero_active,
  input wire logic timer_one_active,
  input wire logic timer_underflow_flag
);
  logic take;
  logic ss_q;
  logic cw_q;
  logic [7:0] ctl_q;
  assign take = hsel && htrans[1] && hready && hwrite && haddr[1:0] == 2'h0;
  // Data-phase markers of writes to start/stop and control
  always_ff @(posedge mclk) begin
    ss_q <= !rst && take && haddr[9:2] == tmr_pkg::IDX_START_STOP;
    cw_q <= !rst && take && haddr[9:2] == tmr_pkg::IDX_T0_CTRL;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_q <= 8'h00;
    end else if (cw_q) begin
      ctl_q <= hwdata[7:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_read_wait_state: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_zero_masked_write: assert property (
    ss_q && hwdata[0] |=> timer_zero_active == $past(hwdata[4]))
    else $error("timer zero run bit not written");
  a_one_masked_write: assert property (
    ss_q && hwdata[1] |=> timer_one_active == $past(hwdata[5]))
    else $error("timer one run bit not written");
  a_one_mask_hold: assert property (
    !(ss_q && hwdata[1]) |=> $stable(timer_one_active))
    else $error("timer one run bit changed unmasked");
  a_flag_when_active: assert property (
    timer_underflow_flag |-> $past(timer_zero_active))
    else $error("underflow flag while stopped");
  a_manual_no_start: assert property (
    ctl_q[5:4] == 2'h0 && !ss_q && !timer_zero_active |=> !timer_zero_active)
    else $error("timer zero started in manual mode");
  a_tx_end_start: assert property (
    ctl_q[5:4] == 2'h1 && tx_end && !rx_first_bits && !timer_zero_active && !ss_q
    |=> timer_zero_active)
    else $error("timer zero not started at tx end");
  a_rx_halt_stop: assert property (
    !ctl_q[5] && ctl_q[7] && rx_first_bits && timer_zero_active && !ss_q
    |=> !timer_zero_active)
    else $error("timer zero not halted on rx");
endmodule

bind tmr_top tmr_chk i_tmr_chk (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .tx_end(tx_end), .rx_first_bits(rx_first_bits),
  .timer_zero_active(timer_zero_active), .timer_one_active(timer_one_active),
  .timer_underflow_flag(timer_underflow_flag));
